//--- rtl/etw_cfg.svh
// constants for the two-wire eeprom client and its host controller
// assumes a 100 MHz system clock on both ends
// Contract
// - respond only when select bits match pins
// - data changes only while clock low
// - falling data with clock high starts
// - rising data with clock high stops
// - host starts only on idle bus; the host start sequence does not sample the lines first
// - one data bit per clock pulse
// - only the last 16 bytes kept
// - every byte acknowledged on ninth pulse
// - no acknowledge during programming cycle
// - acknowledge holds data low through high
// - host nack ends read, client releases
// - control byte: type, selects, direction
// - direction one reads, zero writes
// - word address uses seven low bits
// - acknowledge matching address, enter mode
// - missing third select sent as zero
// - write control acked on ninth pulse
// - word address loads address pointer
// - stop after data launches write cycle
// - write protect blocks array writes only
// - protected write acked, cycle still timed
// - write cycle lasts at most 5 ms
// - pointer wraps from 7F to 00
`ifndef ETW_CFG_SVH
`define ETW_CFG_SVH

`define ETW_CLK_HZ      100000000
`define ETW_TWC_MS      5
`define ETW_TWC_CYCLES  ((`ETW_TWC_MS * `ETW_CLK_HZ) / 1000)
`define ETW_DEV_TYPE    4'h5
// device type code above is an arbitrary value
`define ETW_DEPTH       128
`define ETW_PAGE        16
`define ETW_QTR_CYCLES  16'h0010

// host register offsets
`define ETW_REG_CMD     4'h0
`define ETW_REG_STAT    4'h4
// command register fields
`define ETW_CMD_DATA_LSB 0
`define ETW_CMD_OP_LSB   8
`define ETW_CMD_ACK_BIT  11
// command codes
`define ETW_OP_START    3'h1
`define ETW_OP_STOP     3'h2
`define ETW_OP_WRITE    3'h3
`define ETW_OP_READ     3'h4
// status register fields
`define ETW_STAT_BUSY   0
`define ETW_STAT_ACK    1
`define ETW_STAT_RX_LSB 8

`endif

//--- rtl/etw_pkg.sv
// types shared by the client and host ends
// assumes etw_cfg.svh holds the numeric constants
package etw_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_HOLD} etw_dev_st_t;
  typedef enum logic [1:0] {K_CTRL, K_ADDR, K_DATA} etw_kind_t;
  typedef enum logic {H_IDLE, H_RUN} etw_host_st_t;
endpackage

//--- rtl/etw_bus_if.sv
// open-drain two-wire bus joining host and client
// assumes pull-ups: a line reads high unless an enabled driver pulls it low
`timescale 1ns/100ps
`default_nettype none
interface etw_bus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // wired-and resolution of both lines
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
  modport dev  (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface
`default_nettype wire

//--- rtl/etw_sync.sv
// two-stage synchroniser for pins from outside the clock domain
// assumes inputs idle high; resets to ones
`timescale 1ns/100ps
`default_nettype none
module etw_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // pins in, synchronised out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '1;
      q_o  <= '1;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // etw_sync
`default_nettype wire

//--- rtl/etw_dev.sv
// client end: two-wire eeprom, 128 bytes, page buffer and timed write cycle
// assumes the host drives the clock and meets the bus protocol
`include "etw_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module etw_dev
  import etw_pkg::*;
#(
  parameter int unsigned TWC_CYCLES = `ETW_TWC_CYCLES
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // two-wire link
  etw_bus_if.dev          bus,
  // straps
  input  wire logic       select_line_0_i,
  input  wire logic       select_line_1_i,
  input  wire logic       select_line_2_i,
  input  wire logic       write_protect_i,
  // status
  output logic            busy_o,
  output logic [6:0]      addr_ptr_o
);
  logic [5:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic [2:0]  sel_s;
  logic        wp_s;
  logic        scl_d;
  logic        sda_d;
  logic        start_det;
  logic        stop_det;
  logic        scl_rise;
  logic        scl_fall;
  logic        launch;
  etw_dev_st_t st;
  etw_kind_t   kind;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  txreg;
  logic        sda_oe;
  logic        rd_mode;
  logic        host_ack;
  logic [6:0]  ptr;
  logic [15:0] pvalid;
  logic [7:0]  pbuf [0:`ETW_PAGE-1];
  logic [7:0]  mem [0:`ETW_DEPTH-1];
  logic [7:0]  mem_rd;
  logic [19:0] twc_cnt;

  // all pins cross into the clock domain first
  etw_sync #(.W(6)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({write_protect_i, select_line_2_i, select_line_1_i, select_line_0_i, bus.sda, bus.scl}),
    .q_o   (pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign sel_s = pins_s[4:2];
  assign wp_s  = pins_s[5];

  // previous line levels for edge finding
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // bus conditions and clock edges
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign mem_rd    = mem[ptr];
  // only a stop after buffered data starts the cycle
  assign launch    = stop_det & (|pvalid);

  // open drain: the pin only ever pulls low
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_oe;
  assign addr_ptr_o     = ptr;

  // link state machine: bytes in, acknowledges and bytes out
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st       <= ST_IDLE;
      kind     <= K_CTRL;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      txreg    <= 8'h00;
      sda_oe   <= 1'b0;
      rd_mode  <= 1'b0;
      host_ack <= 1'b0;
      ptr      <= 7'h00;
      pvalid   <= 16'h0000;
    end
    else if (start_det)
    begin
      // a repeated start drops any unwritten page data
      st      <= ST_RX;
      kind    <= K_CTRL;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
      pvalid  <= 16'h0000;
    end
    else if (stop_det)
    begin
      st     <= ST_IDLE;
      sda_oe <= 1'b0;
      pvalid <= 16'h0000;
    end
    else
    begin
      case (st)
        ST_RX:
        begin
          if (scl_rise)
          begin
            // sample once at the high phase, one bit per pulse
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end
          else if (scl_fall && bit_cnt == 4'h8)
          begin
            bit_cnt <= 4'h0;
            case (kind)
              K_CTRL:
              begin
                // busy array keeps silent so the host can poll
                if (shreg[7:4] == `ETW_DEV_TYPE && shreg[3:1] == sel_s && !busy_o)
                begin
                  rd_mode <= shreg[0];
                  kind    <= K_ADDR;
                  sda_oe  <= 1'b1;
                  st      <= ST_ACK;
                end
                else
                begin
                  st <= ST_HOLD;
                end
              end
              K_ADDR:
              begin
                ptr    <= shreg[6:0];
                kind   <= K_DATA;
                sda_oe <= 1'b1;
                st     <= ST_ACK;
              end
              default:
              begin
                // low nibble rolls within the page, oldest byte overwritten
                pbuf[ptr[3:0]]   <= shreg;
                pvalid[ptr[3:0]] <= 1'b1;
                ptr    <= {ptr[6:4], 4'(ptr[3:0] + 4'h1)};
                sda_oe <= 1'b1;
                st     <= ST_ACK;
              end
            endcase
          end
        end
        ST_ACK:
        begin
          // low held from one fall to the next covers the whole high phase
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            if (rd_mode)
            begin
              txreg  <= mem_rd;
              sda_oe <= ~mem_rd[7];
              st     <= ST_TX;
            end
            else
            begin
              sda_oe <= 1'b0;
              st     <= ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == 4'h7)
            begin
              sda_oe  <= 1'b0;
              ptr     <= 7'(ptr + 7'h01);
              bit_cnt <= 4'h0;
              st      <= ST_TXACK;
            end
            else
            begin
              txreg   <= {txreg[6:0], 1'b0};
              sda_oe  <= ~txreg[6];
              bit_cnt <= 4'(bit_cnt + 4'h1);
            end
          end
        end
        ST_TXACK:
        begin
          if (scl_rise)
          begin
            host_ack <= ~sda_s;
          end
          else if (scl_fall)
          begin
            if (host_ack)
            begin
              txreg  <= mem_rd;
              sda_oe <= ~mem_rd[7];
              st     <= ST_TX;
            end
            else
            begin
              st <= ST_HOLD;
            end
          end
        end
        default:
        begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // array update at the stop; protection drops the data, not the cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < `ETW_DEPTH; i++)
      begin
        mem[i] <= 8'h00;
      end
    end
    else if (launch && !wp_s)
    begin
      for (int i = 0; i < `ETW_PAGE; i++)
      begin
        if (pvalid[i])
        begin
          mem[{ptr[6:4], 4'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // self-timed write cycle counted in system clocks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_o  <= 1'b0;
      twc_cnt <= 20'h00000;
    end
    else if (launch)
    begin
      busy_o  <= 1'b1;
      twc_cnt <= 20'(TWC_CYCLES - 1);
    end
    else if (busy_o)
    begin
      if (twc_cnt == 20'h00000)
      begin
        busy_o <= 1'b0;
      end
      else
      begin
        twc_cnt <= 20'(twc_cnt - 20'h00001);
      end
    end
  end
endmodule // etw_dev
`default_nettype wire

//--- rtl/etw_host.sv
// host end: two-wire bus controller commanded over classic wishbone
// assumes the client does not stretch the clock
`include "etw_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module etw_host
  import etw_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // two-wire link
  etw_bus_if.host          bus
);
  logic [1:0]   lines_s;
  logic         req;
  logic         cmd_wr;
  etw_host_st_t st;
  logic [2:0]   op;
  logic [15:0]  tick;
  logic [1:0]   q;
  logic [3:0]   bitn;
  logic [8:0]   txd;
  logic [7:0]   rxd;
  logic         ack_rx;
  logic         scl_oe;
  logic         sda_oe;

  etw_sync #(.W(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({bus.sda, bus.scl}),
    .q_o   (lines_s)
  );

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_scl_oe = scl_oe;
  assign bus.host_sda_oe = sda_oe;

  // a command written while busy is dropped
  assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // command lands on the edge where the master sees ack, not before
  assign cmd_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & (wb_adr_i == `ETW_REG_CMD) & (&wb_sel_i[1:0])
                  & (st == H_IDLE);

  // single-cycle answer, unmapped reads give zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i && wb_adr_i == `ETW_REG_STAT)
      begin
        wb_dat_o <= {16'h0000, rxd, 6'h00, ack_rx, (st == H_RUN)};
      end
      else
      begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // quarter-bit sequencer for start, stop, write and read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st     <= H_IDLE;
      op     <= 3'h0;
      tick   <= 16'h0000;
      q      <= 2'h0;
      bitn   <= 4'h0;
      txd    <= 9'h1FF;
      rxd    <= 8'h00;
      ack_rx <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (st == H_IDLE)
    begin
      if (cmd_wr)
      begin
        op   <= wb_dat_i[`ETW_CMD_OP_LSB +: 3];
        tick <= 16'h0000;
        q    <= 2'h0;
        bitn <= 4'h0;
        st   <= H_RUN;
        if (wb_dat_i[`ETW_CMD_OP_LSB +: 3] == `ETW_OP_WRITE)
        begin
          txd <= {wb_dat_i[`ETW_CMD_DATA_LSB +: 8], 1'b1};
        end
        else
        begin
          txd <= {8'hFF, ~wb_dat_i[`ETW_CMD_ACK_BIT]};
        end
      end
    end
    else if (tick != 16'(`ETW_QTR_CYCLES - 16'h0001))
    begin
      tick <= 16'(tick + 16'h0001);
    end
    else
    begin
      tick <= 16'h0000;
      q    <= 2'(q + 2'h1);
      case (op)
        `ETW_OP_START:
        begin
          case (q)
            2'h0: sda_oe <= 1'b0;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b1;
            default:
            begin
              scl_oe <= 1'b1;
              st     <= H_IDLE;
            end
          endcase
        end
        `ETW_OP_STOP:
        begin
          case (q)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b0;
            default: st <= H_IDLE;
          endcase
        end
        `ETW_OP_WRITE, `ETW_OP_READ:
        begin
          case (q)
            2'h0: sda_oe <= ~txd[8];
            2'h1: scl_oe <= 1'b0;
            2'h2:
            begin
              if (bitn == 4'h8)
              begin
                ack_rx <= ~lines_s[1];
              end
              else
              begin
                rxd <= {rxd[6:0], lines_s[1]};
              end
            end
            default:
            begin
              scl_oe <= 1'b1;
              txd    <= {txd[7:0], 1'b1};
              bitn   <= 4'(bitn + 4'h1);
              if (bitn == 4'h8)
              begin
                st <= H_IDLE;
              end
            end
          endcase
        end
        default: st <= H_IDLE;
      endcase
    end
  end
endmodule // etw_host
`default_nettype wire

//--- dv/etw_link_checker.sv
// link checker: client drive timing and bus conditions
// assumes the bus interface signals are wired in by name
`timescale 1ns/100ps
`default_nettype none
module etw_link_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus lines and enables
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // client data may only move while the clock is low
  property p_dev_still;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  a_dev_still: assert property (p_dev_still)
    else $error("client moved sda with scl high");

  // drive and release follow a clock fall closely
  property p_drive_late;
    $rose(dev_sda_oe) |-> !scl && $past(scl, 8);
  endproperty
  a_drive_late: assert property (p_drive_late)
    else $error("client drive not just after scl fall");
  property p_free_late;
    $fell(dev_sda_oe) |-> !scl && $past(scl, 8);
  endproperty
  a_free_late: assert property (p_free_late)
    else $error("client release not just after scl fall");

  // a pulled line stays low for eight clocks after scl rises
  property p_ack_low;
    $rose(scl) && dev_sda_oe |-> (dev_sda_oe && !sda) [*8];
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("acknowledge not low through scl high");

  // start and stop belong to the host only
  property p_host_start;
    $fell(sda) && scl |-> host_sda_oe && !dev_sda_oe;
  endproperty
  a_host_start: assert property (p_host_start)
    else $error("start not made by host");
  property p_host_stop;
    $rose(sda) && scl |-> !dev_sda_oe;
  endproperty
  a_host_stop: assert property (p_host_stop)
    else $error("stop while client pulls sda");
  property p_quiet_stop;
    $rose(sda) && scl |=> !dev_sda_oe [*8];
  endproperty
  a_quiet_stop: assert property (p_quiet_stop)
    else $error("client drives after stop");

  // each clock pulse has a real high phase
  property p_clk_high;
    $rose(scl) |-> scl [*8];
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("scl high phase too short");
endmodule // etw_link_checker
`default_nettype wire

//--- dv/testbench.sv
// bench: wishbone-driven host talking to the eeprom client
// assumes rtl/etw_cfg.svh on the include path
`include "etw_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // short write cycle keeps the run brief
  localparam int TWC = 2000;
  logic        clk_i;
  logic        rst_i;
  logic [3:0]  adr;
  logic [31:0] wdat;
  logic        we;
  logic        stb;
  logic        cyc;
  logic [31:0] rdat;
  logic        ack;
  logic [2:0]  pins;
  logic        wp;
  logic        busy;
  logic [6:0]  ptr;
  logic [31:0] stat;
  int          fails;
  int          check_count;
  int          bcnt;
  int          i;

  etw_bus_if etw_bus_if_i ();
  etw_host etw_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_dat_o(rdat),
    .wb_ack_o(ack), .bus(etw_bus_if_i));
  etw_dev #(.TWC_CYCLES(TWC)) etw_dev_i (.clk_i(clk_i), .rst_i(rst_i), .bus(etw_bus_if_i),
    .select_line_0_i(pins[0]), .select_line_1_i(pins[1]), .select_line_2_i(pins[2]),
    .write_protect_i(wp), .busy_o(busy), .addr_ptr_o(ptr));
  etw_link_checker etw_link_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .host_scl_oe(etw_bus_if_i.host_scl_oe), .host_sda_oe(etw_bus_if_i.host_sda_oe),
    .dev_sda_oe(etw_bus_if_i.dev_sda_oe), .scl(etw_bus_if_i.scl), .sda(etw_bus_if_i.sda));

  // free-running system clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // total clocks spent in write cycles since start, never cleared
  always @(posedge clk_i)
    if (busy === 1'b1)
      bcnt <= bcnt + 1;

  task automatic complete_run;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // a bounded wait ran out
  task automatic hang;
    fails++;
    complete_run();
  endtask

  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_bit(input logic e, input logic g);
    chk_byte({7'h0, e}, {7'h0, g});
  endtask

  // classic single wishbone cycle, read data kept in stat
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge clk_i);
    stat = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20)
      hang();
  endtask

  // one host command, then poll until the controller is free
  task automatic op(input logic [2:0] o, input logic [7:0] d, input logic a);
    int n;
    wb(1'b1, `ETW_REG_CMD, {20'h0, a, o, d});
    stat = 32'h1;
    for (n = 0; n < 2000 && stat[`ETW_STAT_BUSY] !== 1'b0; n++)
      wb(1'b0, `ETW_REG_STAT, 32'h0);
    if (n == 2000)
      hang();
  endtask

  task automatic wbyte(input logic [7:0] d, input logic e);
    op(`ETW_OP_WRITE, d, 1'b0);
    chk_bit(e, stat[`ETW_STAT_ACK]);
  endtask

  task automatic rbyte(input logic [7:0] e, input logic a);
    op(`ETW_OP_READ, 8'h00, a);
    chk_byte(e, stat[15:8]);
  endtask

  // start plus control byte: type, selects, direction
  task automatic ctl(input logic [2:0] s, input logic r, input logic e);
    op(`ETW_OP_START, 8'h00, 1'b0);
    wbyte({`ETW_DEV_TYPE, s, r}, e);
  endtask

  task automatic seta(input logic [7:0] a);
    ctl(pins, 1'b0, 1'b1);
    wbyte(a, 1'b1);
  endtask

  task automatic stop;
    op(`ETW_OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic drain;
    int n;
    for (n = 0; n < 3000 && busy !== 1'b0; n++)
      @(posedge clk_i);
    if (n == 3000)
      hang();
  endtask

  // main sequence
  initial
  begin
    rst_i = 1'b1;
    adr = 4'h0;
    wdat = 32'h0;
    we = 1'b0;
    stb = 1'b0;
    cyc = 1'b0;
    pins = 3'h6;
    wp = 1'b0;
    bcnt = 0;
    fails = 0;
    check_count = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);

    // byte write with address msb set, polled while busy
    chk_bit(1'b1, etw_bus_if_i.scl & etw_bus_if_i.sda);
    seta(8'hFF);
    chk_byte(8'h7F, {1'b0, ptr});
    wbyte(8'hA5, 1'b1);
    stop();
    chk_bit(1'b1, busy);
    ctl(pins, 1'b0, 1'b0);
    stop();
    drain();
    chk_bit(1'b1, bcnt >= TWC - 2 && bcnt <= TWC);
    $display("test byte write done");

    // random read across the top of the array
    seta(8'h7F);
    ctl(pins, 1'b1, 1'b1);
    rbyte(8'hA5, 1'b1);
    chk_byte(8'h00, {1'b0, ptr});
    rbyte(8'h00, 1'b0);
    stop();
    chk_byte(8'h01, {1'b0, ptr});
    $display("test wrap read done");

    // every select code, then a wrong type code
    for (i = 0; i < 8; i++)
    begin
      ctl(i[2:0], 1'b0, i[2:0] == pins);
      stop();
    end
    op(`ETW_OP_START, 8'h00, 1'b0);
    wbyte({`ETW_DEV_TYPE ^ 4'h1, pins, 1'b0}, 1'b0);
    stop();
    // part without the third select: that bit goes out as zero
    pins <= 3'h3;
    repeat (4) @(posedge clk_i);
    ctl(3'h3, 1'b0, 1'b1);
    stop();
    pins <= 3'h6;
    repeat (4) @(posedge clk_i);
    $display("test selects done");

    // eighteen bytes into one page keeps the last sixteen
    seta(8'h20);
    for (i = 0; i < 18; i++)
      wbyte(8'h10 + i[7:0], 1'b1);
    stop();
    drain();
    seta(8'h20);
    ctl(pins, 1'b1, 1'b1);
    for (i = 0; i < 16; i++)
      rbyte(i < 2 ? 8'h20 + i[7:0] : 8'h10 + i[7:0], i < 15);
    stop();
    $display("test page done");

    // protected write is acked and timed but not stored
    wp <= 1'b1;
    seta(8'h22);
    wbyte(8'h00, 1'b1);
    stop();
    chk_bit(1'b1, busy);
    drain();
    seta(8'h22);
    ctl(pins, 1'b1, 1'b1);
    rbyte(8'h12, 1'b0);
    stop();
    wp <= 1'b0;
    $display("test protect done");
    complete_run();
  end
endmodule // testbench
`default_nettype wire
